// ### iaw_pkg.sv
// ---------------------------------------------------------------------------
// Constants shared by the interrupt aggregator and watchdog.
// ---------------------------------------------------------------------------
package iaw_pkg;

   localparam int unsigned ADDR_W   = 16;
   localparam int unsigned DATA_W   = 8;
   localparam int unsigned NUM_PINS = 10;
   localparam int unsigned NUM_DRV  = 3;
   localparam int unsigned WDT_W    = 16;

   // ------------------------------------------------------------------------
   // Register addresses.
   // ------------------------------------------------------------------------
   localparam logic [15:0] ADDR_IO_UPDATE  = 16'h000F;
   localparam logic [15:0] ADDR_DRV_BASE   = 16'h0100;
   localparam logic [15:0] ADDR_FUNC_BASE  = 16'h0103;
   localparam logic [15:0] ADDR_WDT_LO     = 16'h010D;
   localparam logic [15:0] ADDR_WDT_HI     = 16'h010E;
   localparam logic [15:0] ADDR_MASK       = 16'h010F;
   localparam logic [15:0] ADDR_CLEAR      = 16'h0A05;
   localparam logic [15:0] ADDR_STATUS     = 16'h0D08;

   localparam logic [7:0]  IO_UPDATE_VALUE = 8'h01;

   // ------------------------------------------------------------------------
   // Bit positions in the clear, mask and status banks.
   // ------------------------------------------------------------------------
   localparam int unsigned CLR_ALL_BIT     = 0;
   localparam int unsigned WDT_RESTART_BIT = 7;
   localparam int unsigned BIT_WDT         = 1;
   localparam int unsigned BIT_COMMON      = 2;
   localparam int unsigned BIT_LOOP0       = 3;
   localparam logic [7:0]  SRC_VALID_MASK  = 8'h7E;
   localparam logic [7:0]  CAT_COMMON_MASK = 8'h06;

   // ------------------------------------------------------------------------
   // Pin function register layout and codes.
   // ------------------------------------------------------------------------
   localparam int unsigned FUNC_DIR_BIT    = 7;
   localparam logic [6:0]  OUT_IRQ_ALL     = 7'h01;
   localparam logic [6:0]  OUT_IRQ_COMMON  = 7'h02;
   localparam logic [6:0]  OUT_IRQ_LOOP0   = 7'h03;
   localparam logic [6:0]  OUT_IRQ_LOOP1   = 7'h04;
   localparam logic [6:0]  OUT_IRQ_LOOP2   = 7'h05;
   localparam logic [6:0]  OUT_IRQ_LOOP3   = 7'h06;
   localparam logic [6:0]  OUT_WDT_PULSE   = 7'h07;
   localparam logic [6:0]  IN_CLEAR_ALL    = 7'h01;
   localparam logic [6:0]  IN_WDT_RESTART  = 7'h02;

   // ------------------------------------------------------------------------
   // Drive modes and reset values.
   // ------------------------------------------------------------------------
   localparam logic [1:0]  DRV_HIGH_PP     = 2'h0;
   localparam logic [1:0]  DRV_LOW_PP      = 2'h1;
   localparam logic [1:0]  DRV_HIGH_OD     = 2'h2;
   localparam logic [1:0]  DRV_LOW_OD      = 2'h3;
   localparam logic [7:0]  RST_BYTE        = 8'h00;
   localparam logic [15:0] RST_WDT         = 16'h0000;

   // ------------------------------------------------------------------------
   // Timing.
   // ------------------------------------------------------------------------
   localparam int unsigned CLK_FREQ_MHZ    = 200;
   localparam int unsigned WDT_TICK_US     = 1000;
   localparam int unsigned WDT_MS_CYCLES   = WDT_TICK_US * CLK_FREQ_MHZ;
   localparam logic [6:0]  WDT_PULSE_CYC   = 7'h60;

endpackage

// ### iaw_watchdog.sv
`timescale 1ns/1ps
module iaw_watchdog #(
   parameter int unsigned MS_CYCLES = iaw_pkg::WDT_MS_CYCLES
) (
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        srst,
   // Control.
   input  wire logic [15:0] period,
   input  wire logic        restart,
   // Timeout indications.
   output logic             timeout_evt,
   output logic             timeout_pulse
);
   import iaw_pkg::*;

   localparam int unsigned PW = $clog2(MS_CYCLES + 1);
   localparam logic [PW-1:0] PRESC_LAST = PW'(MS_CYCLES - 1);

   logic [PW-1:0]    presc_reg;
   logic [WDT_W-1:0] ms_reg;
   logic [6:0]       pulse_cnt_reg;

   // ------------------------------------------------------------------------
   // Millisecond prescaler and timeout counter.
   // ------------------------------------------------------------------------
   // zero disables, restart wins
   always_ff @(posedge clk) begin
      if (srst || period == RST_WDT || restart) begin
         presc_reg   <= '0;
         ms_reg      <= '0;
         timeout_evt <= 1'b0;
      end else begin
         timeout_evt <= 1'b0;
         if (presc_reg == PRESC_LAST) begin
            presc_reg <= '0;
            if (ms_reg >= period - 16'h0001) begin
               ms_reg      <= '0;
               timeout_evt <= 1'b1;
            end else begin
               ms_reg <= ms_reg + 16'h0001;
            end
         end else begin
            presc_reg <= presc_reg + PW'(1);
         end
      end
   end

   // ------------------------------------------------------------------------
   // Pin pulse stretcher.
   // ------------------------------------------------------------------------
   // pulse of 96 cycles
   always_ff @(posedge clk) begin
      if (srst) begin
         pulse_cnt_reg <= '0;
         timeout_pulse <= 1'b0;
      end else if (timeout_evt) begin
         pulse_cnt_reg <= WDT_PULSE_CYC;
         timeout_pulse <= 1'b1;
      end else if (pulse_cnt_reg > 7'h01) begin
         pulse_cnt_reg <= pulse_cnt_reg - 7'h01;
      end else begin
         pulse_cnt_reg <= '0;
         timeout_pulse <= 1'b0;
      end
   end

endmodule // iaw_watchdog

// ### iaw_pin_cell.sv
`timescale 1ns/1ps
module iaw_pin_cell (
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       srst,
   // Configuration.
   input  wire logic [1:0] mode,
   input  wire logic       drive_en,
   input  wire logic       asserted,
   // Pad signals.
   input  wire logic       pad_in,
   output logic            pad_out,
   output logic            pad_oe,
   // Synchronised input, true when the pin asserts.
   output logic            in_asserted
);
   import iaw_pkg::*;

   logic sync1_reg;
   logic sync2_reg;

   // ------------------------------------------------------------------------
   // Output drive.
   // ------------------------------------------------------------------------
   // four drive modes
   always_ff @(posedge clk) begin
      if (srst || !drive_en) begin
         pad_out <= 1'b0;
         pad_oe  <= 1'b0;
      end else begin
         case (mode)
            DRV_HIGH_PP: begin
               pad_out <= asserted;
               pad_oe  <= 1'b1;
            end
            DRV_LOW_PP: begin
               pad_out <= ~asserted;
               pad_oe  <= 1'b1;
            end
            DRV_HIGH_OD: begin
               pad_out <= 1'b1;
               pad_oe  <= asserted;
            end
            default: begin
               pad_out <= 1'b0;
               pad_oe  <= asserted;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------------
   // Input synchroniser; low-true modes invert the sense.
   // ------------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         sync1_reg   <= 1'b0;
         sync2_reg   <= 1'b0;
         in_asserted <= 1'b0;
      end else begin
         sync1_reg   <= pad_in;
         sync2_reg   <= sync1_reg;
         in_asserted <= sync2_reg ^ mode[0];
      end
   end

endmodule // iaw_pin_cell

// ### iaw_top.sv
`timescale 1ns/1ps
module iaw_top #(
   parameter int unsigned MS_CYCLES = iaw_pkg::WDT_MS_CYCLES
) (
   // Clock and reset.
   input  wire logic                         clk,
   input  wire logic                         srst,
   // Register access port.
   input  wire logic                         reg_wr_en,
   input  wire logic                         reg_rd_en,
   input  wire logic [iaw_pkg::ADDR_W-1:0]   reg_addr,
   input  wire logic [iaw_pkg::DATA_W-1:0]   reg_wdata,
   output logic      [iaw_pkg::DATA_W-1:0]   reg_rdata,
   output logic                              reg_rvalid,
   // Internal interrupt conditions.
   input  wire logic [3:0]                   loop_alarm,
   input  wire logic                         common_alarm,
   // Multifunction pins.
   input  wire logic [iaw_pkg::NUM_PINS-1:0] mfp_in,
   output logic      [iaw_pkg::NUM_PINS-1:0] mfp_out,
   output logic      [iaw_pkg::NUM_PINS-1:0] mfp_oe
);
   import iaw_pkg::*;

   // ------------------------------------------------------------------------
   // Storage.
   // ------------------------------------------------------------------------
   logic [WDT_W-1:0]  wdt_period_reg;
   logic [7:0]        mask_reg;
   logic [7:0]        status_reg;
   logic [7:0]        status_next;
   logic [7:0]        cond_prev_reg;
   logic [7:0]        func_shadow_reg [NUM_PINS];
   logic [7:0]        func_active_reg [NUM_PINS];
   logic [NUM_PINS-1:0] func_live_reg;
   logic [7:0]        drv_reg [NUM_DRV];

   // ------------------------------------------------------------------------
   // Decoded strobes and internal nets.
   // ------------------------------------------------------------------------
   logic              io_update;
   logic              clr_wr;
   logic              clear_all;
   logic              wd_restart;
   logic [NUM_PINS-1:0] pin_clear;
   logic [NUM_PINS-1:0] pin_restart;
   logic [7:0]        cond;
   logic [7:0]        gated;
   logic [7:0]        rise;
   logic [7:0]        clr_vec;
   logic              irq_any;
   logic              irq_common;
   logic              wdt_evt;
   logic              wdt_pulse;
   logic [7:0]        rd_val;
   logic [15:0]       func_off;
   logic [15:0]       drv_off;

   assign io_update = reg_wr_en && reg_addr == ADDR_IO_UPDATE && reg_wdata == IO_UPDATE_VALUE;
   assign clr_wr    = reg_wr_en && reg_addr == ADDR_CLEAR;
   assign func_off  = reg_addr - ADDR_FUNC_BASE;
   assign drv_off   = reg_addr - ADDR_DRV_BASE;

   assign clear_all  = (clr_wr && reg_wdata[CLR_ALL_BIT]) || (|pin_clear);
   assign wd_restart = (clr_wr && reg_wdata[WDT_RESTART_BIT]) || (|pin_restart);

   // ------------------------------------------------------------------------
   // Configuration registers.
   // ------------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         wdt_period_reg <= RST_WDT;
         mask_reg       <= RST_BYTE;
      end else if (reg_wr_en) begin
         if (reg_addr == ADDR_WDT_LO) begin
            wdt_period_reg[7:0] <= reg_wdata;
         end
         if (reg_addr == ADDR_WDT_HI) begin
            wdt_period_reg[15:8] <= reg_wdata;
         end
         if (reg_addr == ADDR_MASK) begin
            mask_reg <= reg_wdata;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         for (int i = 0; i < NUM_DRV; i++) begin
            drv_reg[i] <= RST_BYTE;
         end
      end else if (reg_wr_en && drv_off < 16'(NUM_DRV)) begin
         drv_reg[drv_off[1:0]] <= reg_wdata;
      end
   end

   // ------------------------------------------------------------------------
   // Pin function registers with staged activation.
   // ------------------------------------------------------------------------
   // stop on write, apply on update
   always_ff @(posedge clk) begin
      if (srst) begin
         func_live_reg <= '1;
         for (int i = 0; i < NUM_PINS; i++) begin
            func_shadow_reg[i] <= RST_BYTE;
            func_active_reg[i] <= RST_BYTE;
         end
      end else if (io_update) begin
         func_live_reg <= '1;
         for (int i = 0; i < NUM_PINS; i++) begin
            func_active_reg[i] <= func_shadow_reg[i];
         end
      end else if (reg_wr_en && func_off < 16'(NUM_PINS)) begin
         func_shadow_reg[func_off[3:0]] <= reg_wdata;
         func_live_reg[func_off[3:0]]   <= 1'b0;
      end
   end

   // ------------------------------------------------------------------------
   // Interrupt capture.
   // ------------------------------------------------------------------------
   always_comb begin
      cond             = '0;
      cond[BIT_WDT]    = wdt_evt;
      cond[BIT_COMMON] = common_alarm;
      for (int k = 0; k < 4; k++) begin
         cond[BIT_LOOP0 + k] = loop_alarm[k];
      end
   end

   assign gated = cond & mask_reg & SRC_VALID_MASK;
   assign rise  = gated & ~cond_prev_reg;
   assign clr_vec = clear_all ? 8'hFF : ((clr_wr ? reg_wdata : 8'h00) & SRC_VALID_MASK);
   assign status_next = (status_reg & ~clr_vec) | rise;

   always_ff @(posedge clk) begin
      if (srst) begin
         status_reg    <= RST_BYTE;
         cond_prev_reg <= RST_BYTE;
      end else begin
         status_reg    <= status_next;
         cond_prev_reg <= gated;
      end
   end

   assign irq_any    = |status_reg;
   assign irq_common = |(status_reg & CAT_COMMON_MASK);

   // ------------------------------------------------------------------------
   // Watchdog.
   // ------------------------------------------------------------------------
   iaw_watchdog #(
      .MS_CYCLES (MS_CYCLES)
   ) u_wdt (
      .clk           (clk),
      .srst          (srst),
      .period        (wdt_period_reg),
      .restart       (wd_restart),
      .timeout_evt   (wdt_evt),
      .timeout_pulse (wdt_pulse)
   );

   // ------------------------------------------------------------------------
   // Multifunction pins.
   // ------------------------------------------------------------------------
   for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
      logic [6:0] fsel;
      logic       is_out;
      logic       is_in;
      logic       asserted;
      logic       in_level;
      logic [1:0] mode;

      assign fsel   = func_active_reg[p][6:0];
      assign is_out = func_live_reg[p] && func_active_reg[p][FUNC_DIR_BIT];
      assign is_in  = func_live_reg[p] && !func_active_reg[p][FUNC_DIR_BIT];
      assign mode   = drv_reg[p / 4][(p % 4) * 2 +: 2];

      always_comb begin
         case (fsel)
            OUT_IRQ_ALL:    asserted = irq_any;
            OUT_IRQ_COMMON: asserted = irq_common;
            OUT_IRQ_LOOP0:  asserted = status_reg[BIT_LOOP0];
            OUT_IRQ_LOOP1:  asserted = status_reg[BIT_LOOP0 + 1];
            OUT_IRQ_LOOP2:  asserted = status_reg[BIT_LOOP0 + 2];
            OUT_IRQ_LOOP3:  asserted = status_reg[BIT_LOOP0 + 3];
            OUT_WDT_PULSE:  asserted = wdt_pulse;
            default:        asserted = 1'b0;
         endcase
      end

      iaw_pin_cell u_cell (
         .clk         (clk),
         .srst        (srst),
         .mode        (mode),
         .drive_en    (is_out),
         .asserted    (asserted),
         .pad_in      (mfp_in[p]),
         .pad_out     (mfp_out[p]),
         .pad_oe      (mfp_oe[p]),
         .in_asserted (in_level)
      );

      assign pin_clear[p]   = is_in && fsel == IN_CLEAR_ALL && in_level;
      assign pin_restart[p] = is_in && fsel == IN_WDT_RESTART && in_level;
   end

   // ------------------------------------------------------------------------
   // Register read.
   // ------------------------------------------------------------------------
   always_comb begin
      rd_val = 8'h00;
      if (reg_addr == ADDR_WDT_LO) begin
         rd_val = wdt_period_reg[7:0];
      end else if (reg_addr == ADDR_WDT_HI) begin
         rd_val = wdt_period_reg[15:8];
      end else if (reg_addr == ADDR_MASK) begin
         rd_val = mask_reg;
      end else if (reg_addr == ADDR_STATUS) begin
         rd_val = status_reg;
      end else if (func_off < 16'(NUM_PINS)) begin
         rd_val = func_shadow_reg[func_off[3:0]];
      end else if (drv_off < 16'(NUM_DRV)) begin
         rd_val = drv_reg[drv_off[1:0]];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rdata  <= reg_rd_en ? rd_val : 8'h00;
         reg_rvalid <= reg_rd_en;
      end
   end

endmodule // iaw_top

// ### iaw_checker.sv
`timescale 1ns/1ps
module iaw_checker (
   // Clock and reset.
   input wire logic                         clk,
   input wire logic                         srst,
   // Register access port.
   input wire logic                         reg_wr_en,
   input wire logic                         reg_rd_en,
   input wire logic [iaw_pkg::ADDR_W-1:0]   reg_addr,
   input wire logic [iaw_pkg::DATA_W-1:0]   reg_wdata,
   input wire logic [iaw_pkg::DATA_W-1:0]   reg_rdata,
   input wire logic                         reg_rvalid,
   // Multifunction pins.
   input wire logic [iaw_pkg::NUM_PINS-1:0] mfp_out,
   input wire logic [iaw_pkg::NUM_PINS-1:0] mfp_oe
);
   import iaw_pkg::*;
   logic [7:0] fwr_reg;
   logic [7:0] func_reg;
   logic [7:0] hi_cnt_reg;
   logic [1:0] mode_reg;
   logic       act;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   // ------------------------------------------------------------------------
   // Shadow of pin zero's applied function, drive mode and high time.
   // ------------------------------------------------------------------------
   assign act = func_reg[7] && func_reg[6:0] != 7'h00 && func_reg[6:0] <= OUT_WDT_PULSE;
   always_ff @(posedge clk) begin
      if (srst) begin
         fwr_reg <= RST_BYTE;
         func_reg <= RST_BYTE;
      end else if (reg_wr_en && reg_addr == ADDR_FUNC_BASE) begin
         fwr_reg <= reg_wdata;
         func_reg <= RST_BYTE;
      end else if (reg_wr_en && reg_addr == ADDR_IO_UPDATE && reg_wdata == IO_UPDATE_VALUE) begin
         func_reg <= fwr_reg;
      end
   end
   always_ff @(posedge clk) begin
      if (srst)
         mode_reg <= DRV_HIGH_PP;
      else if (reg_wr_en && reg_addr == ADDR_DRV_BASE)
         mode_reg <= reg_wdata[1:0];
   end
   always_ff @(posedge clk) begin
      if (srst || !mfp_out[0])
         hi_cnt_reg <= 8'h00;
      else
         hi_cnt_reg <= hi_cnt_reg + 8'h01;
   end
   // ------------------------------------------------------------------------
   // Assertions.
   // ------------------------------------------------------------------------
   sequence rd_of(logic [15:0] a);
      reg_rd_en && reg_addr == a;
   endsequence
   sequence pulse_end;
      $fell(mfp_out[0]) && func_reg == {1'b1, OUT_WDT_PULSE} && mode_reg == DRV_HIGH_PP;
   endsequence
   reset_quiet_a: assert property ($fell(srst) |-> mfp_oe == '0 && mfp_out == '0)
      else $error("pins driven after reset");
   read_answer_a: assert property (reg_rvalid == $past(reg_rd_en))
      else $error("read answer not one cycle after request");
   rdata_quiet_a: assert property (!reg_rvalid |-> reg_rdata == 8'h00)
      else $error("read data not zero outside answer");
   clr_read_zero_a: assert property (rd_of(ADDR_CLEAR) |=> reg_rdata == 8'h00)
      else $error("clear bank read not zero");
   status_spare_a: assert property (rd_of(ADDR_STATUS) |=> (reg_rdata & ~SRC_VALID_MASK) == 8'h00)
      else $error("status bit without source set");
   pin_idle_a: assert property (!act [*3] |-> !mfp_oe[0])
      else $error("pin drives while its function is stopped");
   pp_drive_a: assert property ((act && !mode_reg[1] && $stable(mode_reg)) [*3] |-> mfp_oe[0])
      else $error("push-pull pin not driven");
   od_drive_a: assert property ((act && mode_reg[1] && $stable(mode_reg)) [*3] ##0 mfp_oe[0] |-> mfp_out[0] == !mode_reg[0])
      else $error("open-drain pin drives wrong level");
   wdt_width_a: assert property (pulse_end |-> hi_cnt_reg == 8'h60)
      else $error("watchdog pulse width wrong");
endmodule // iaw_checker

bind iaw_top iaw_checker u_chk (
   .clk(clk), .srst(srst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .reg_rvalid(reg_rvalid), .mfp_out(mfp_out), .mfp_oe(mfp_oe)
);

// ### iaw_host_model.sv
`timescale 1ns/1ps
module iaw_host_model #(
   parameter logic [iaw_pkg::NUM_PINS-1:0] PULL_UP = '0
) (
   // Pads as the device drives them.
   input  wire logic [iaw_pkg::NUM_PINS-1:0] mfp_out,
   input  wire logic [iaw_pkg::NUM_PINS-1:0] mfp_oe,
   // Host drive requests.
   input  wire logic [iaw_pkg::NUM_PINS-1:0] host_en,
   input  wire logic [iaw_pkg::NUM_PINS-1:0] host_val,
   // Resolved pad levels.
   output logic      [iaw_pkg::NUM_PINS-1:0] mfp_in
);
   import iaw_pkg::*;
   // Undriven lines settle to their resistor level.
   // host asserts inputs
   assign mfp_in = (mfp_oe & mfp_out) | (~mfp_oe & host_en & host_val) | (~mfp_oe & ~host_en & PULL_UP);
endmodule // iaw_host_model

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import iaw_pkg::*;
   localparam logic [15:0] RA [6] = '{ADDR_WDT_LO, ADDR_WDT_HI, ADDR_MASK, ADDR_CLEAR,
                                      ADDR_STATUS, 16'h0200};
   logic        clk, srst, wr_en, rd_en, rvalid, common_alarm, prv0;
   logic [15:0] addr;
   logic [7:0]  wdata, rdata;
   logic [3:0]  loop_alarm;
   logic [9:0]  mfp_in, mfp_out, mfp_oe, host_en, host_val;
   int          err_count = 0, total_checks = 0, n0;
   int          n_rise = 0, ncyc = 0, last_rise = 0, gap = 0, hlen = 0, wid = 0;

   iaw_top #(.MS_CYCLES(10)) DUT (.clk(clk), .srst(srst), .reg_wr_en(wr_en),
      .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
      .reg_rvalid(rvalid), .loop_alarm(loop_alarm), .common_alarm(common_alarm),
      .mfp_in(mfp_in), .mfp_out(mfp_out), .mfp_oe(mfp_oe));
   iaw_host_model HOST (.mfp_out(mfp_out), .mfp_oe(mfp_oe), .host_en(host_en),
      .host_val(host_val), .mfp_in(mfp_in));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // ------------------------------------------------------------------------
   // Pin zero rise, gap and width monitor.
   // ------------------------------------------------------------------------
   always @(posedge clk) begin
      ncyc <= ncyc + 1;
      prv0 <= mfp_out[0];
      if (mfp_out[0] === 1'b1 && prv0 === 1'b0) begin
         n_rise <= n_rise + 1;
         gap <= ncyc - last_rise;
         last_rise <= ncyc;
      end
      if (mfp_out[0] === 1'b1)
         hlen <= hlen + 1;
      else if (hlen != 0) begin
         wid <= hlen;
         hlen <= 0;
      end
   end
   // ------------------------------------------------------------------------
   // Access tasks.
   // ------------------------------------------------------------------------
   task automatic cyc(input int k);
      repeat (k) @(negedge clk);
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk);
      wr_en = 1'b1;
      addr = a;
      wdata = d;
      @(negedge clk);
      wr_en = 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(negedge clk);
      rd_en = 1'b1;
      addr = a;
      @(negedge clk);
      rd_en = 1'b0;
      chk({7'h00, rvalid, rdata}, {8'h01, e});
   endtask
   task automatic setfn(input int p, input logic [7:0] f);
      wr(ADDR_FUNC_BASE + 16'(p), f);
   endtask
   task automatic src(input int k, input logic v);
      if (k == 0)
         common_alarm = v;
      else
         loop_alarm[k-1] = v;
   endtask
   task automatic wait_rise(input int lim);
      int n, t;
      n = n_rise;
      t = 0;
      while (n_rise == n && t < lim) begin
         @(negedge clk);
         t++;
      end
      chk(16'(t < lim), 16'h0001);
   endtask
   task automatic end_sim();
      $display("checks=%0d errors=%0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      #100000;
      err_count++;
      end_sim();
   end
   // ------------------------------------------------------------------------
   // Test sequence.
   // ------------------------------------------------------------------------
   initial begin
      {srst, wr_en, rd_en, addr, wdata} = {3'b100, 16'h0000, 8'h00};
      {loop_alarm, common_alarm, host_en, host_val} = '0;
      cyc(6);
      srst = 1'b0;
      foreach (RA[i]) rd(RA[i], 8'h00);
      wr(ADDR_WDT_HI, 8'hFF);
      rd(ADDR_WDT_HI, 8'hFF);
      wr(ADDR_WDT_HI, 8'h00);
      wr(16'h0200, 8'h5A);
      rd(16'h0200, 8'h00);
      loop_alarm[0] = 1'b1;
      cyc(4);
      rd(ADDR_STATUS, 8'h00);
      wr(ADDR_MASK, 8'h08);
      cyc(3);
      rd(ADDR_STATUS, 8'h08);
      wr(ADDR_CLEAR, 8'h08);
      cyc(3);
      rd(ADDR_STATUS, 8'h00);
      loop_alarm[0] = 1'b0;
      cyc(3);
      loop_alarm[0] = 1'b1;
      cyc(3);
      wr(ADDR_MASK, 8'h00);
      cyc(3);
      rd(ADDR_STATUS, 8'h08);
      wr(ADDR_CLEAR, 8'h01);
      cyc(2);
      rd(ADDR_STATUS, 8'h00);
      loop_alarm[0] = 1'b0;
      wr(ADDR_MASK, 8'h7E);
      for (int p = 0; p < 6; p++) setfn(p, 8'h81 + 8'(p));
      wr(ADDR_IO_UPDATE, IO_UPDATE_VALUE);
      for (int k = 0; k < 5; k++) begin
         src(k, 1'b1);
         cyc(5);
         chk({mfp_oe[5:0], mfp_out[5:0]}, {6'h3F, 6'h01 | (6'h02 << k)});
         wr(ADDR_CLEAR, 8'h04 << k);
         cyc(4);
         chk({mfp_oe[5:0], mfp_out[5:0]}, {6'h3F, 6'h00});
         src(k, 1'b0);
      end
      @(negedge clk);
      {wr_en, addr, wdata} = {1'b1, ADDR_CLEAR, 8'h40};
      loop_alarm[3] = 1'b1;
      @(negedge clk);
      wr_en = 1'b0;
      rd(ADDR_STATUS, 8'h40);
      setfn(7, {1'b0, IN_CLEAR_ALL});
      wr(ADDR_IO_UPDATE, IO_UPDATE_VALUE);
      {host_en[7], host_val[7]} = 2'b11;
      cyc(6);
      host_val[7] = 1'b0;
      cyc(4);
      rd(ADDR_STATUS, 8'h00);
      loop_alarm[3] = 1'b0;
      common_alarm = 1'b1;
      setfn(1, 8'h82);
      cyc(3);
      chk(16'(mfp_oe[1]), 16'h0000);
      wr(ADDR_IO_UPDATE, IO_UPDATE_VALUE);
      cyc(3);
      chk(16'(mfp_oe[1] & mfp_out[1]), 16'h0001);
      for (int m = 0; m < 4; m++) begin
         wr(ADDR_DRV_BASE, 8'(m));
         cyc(3);
         chk({mfp_oe[0], mfp_out[0]}, {1'b1, ~m[0]});
      end
      wr(ADDR_CLEAR, 8'h01);
      for (int m = 0; m < 4; m++) begin
         wr(ADDR_DRV_BASE, 8'(m));
         cyc(3);
         chk({mfp_oe[0], mfp_out[0] & mfp_oe[0]}, {~m[1], m[0] & ~m[1]});
      end
      wr(ADDR_DRV_BASE, 8'h00);
      common_alarm = 1'b0;
      wr(ADDR_MASK, 8'h02);
      setfn(0, {1'b1, OUT_WDT_PULSE});
      setfn(8, {1'b0, IN_WDT_RESTART});
      wr(ADDR_IO_UPDATE, IO_UPDATE_VALUE);
      wr(ADDR_WDT_LO, 8'h14);
      wait_rise(400);
      cyc(110);
      chk(16'(wid), 16'h0060);
      rd(ADDR_STATUS, 8'h02);
      wait_rise(400);
      chk(16'(gap), 16'h00C8);
      n0 = n_rise;
      repeat (3) begin
         cyc(120);
         wr(ADDR_CLEAR, 8'h80);
      end
      chk(16'(n_rise - n0), 16'h0000);
      {host_en[8], host_val[8]} = 2'b11;
      cyc(450);
      host_val[8] = 1'b0;
      chk(16'(n_rise - n0), 16'h0000);
      wait_rise(400);
      wr(ADDR_WDT_LO, 8'h00);
      cyc(5);
      n0 = n_rise;
      cyc(500);
      chk(16'(n_rise - n0), 16'h0000);
      end_sim();
   end
endmodule // tb_top
